/* File: shared/emb_pkg.sv */
// constants and types shared by the embedded memory block and its leaves
// assumes one system clock; slower port rates arrive as clock enables
package emb_pkg;

   // ==========================================================
   // storage geometry
   localparam int WORD_W = 32;
   localparam int DEPTH = 32;
   localparam int ADDR_W = 5;
   localparam int UNENC_W = 16;
   localparam int N_MC = 4;

   // ==========================================================
   // cam write timing, in clock cycles
   localparam logic [1:0] CAM_WR_CYCLES = 2'h2;
   localparam logic [1:0] CAM_WR_DC_CYCLES = 2'h3;

   // ==========================================================
   // reset values
   localparam logic [WORD_W-1:0] RST_WORD = 32'h00000000;
   localparam logic [ADDR_W:0] RST_COUNT = 6'h00;

   // ==========================================================
   // modes and macrocell register kinds
   typedef enum logic [1:0] {MODE_RAM, MODE_ROM, MODE_FIFO, MODE_CAM} mode_t;
   typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} ff_kind_t;

endpackage : emb_pkg

/* File: hdl/mem_store.sv */
// word store with one write port and one registered read port
// assumes write and read requests are already qualified by their enables
`timescale 1ns/1ps
module mem_store
   import emb_pkg::*;
#(
   parameter int W = WORD_W,
   parameter int D = DEPTH,
   parameter int AW = ADDR_W,
   parameter logic [W-1:0] INIT = '0
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [W-1:0] i_wdata,
   input wire logic i_re,
   input wire logic [AW-1:0] i_raddr,
   output logic [W-1:0] o_rdata
);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [W-1:0] rdata;
   } store_t;

   store_t s;
   store_t next_s;

   always_comb
   begin
      next_s = s;
      if (i_we)
      begin
         next_s.mem[i_waddr] = i_wdata;
      end
      if (i_re)
      begin
         next_s.rdata = s.mem[i_raddr];
      end
   end

   // contents preload at reset stands in for configuration load
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         s <= {{D{INIT}}, {W{1'b0}}};
      else
         s <= next_s;
   end

   assign o_rdata = s.rdata;

endmodule : mem_store

/* File: hdl/cam_core.sv */
// content-addressable store with per-bit don't-care and two output forms
// assumes the writer holds a write request until o_wr_done
`timescale 1ns/1ps
module cam_core
   import emb_pkg::*;
#(
   parameter int ENTRIES = DEPTH,
   parameter int W = WORD_W,
   parameter int AW = ADDR_W
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_wr,
   input wire logic i_wr_care,
   input wire logic [AW-1:0] i_wr_addr,
   input wire logic [W-1:0] i_wr_data,
   input wire logic [W-1:0] i_wr_dc,
   input wire logic i_search,
   input wire logic [W-1:0] i_key,
   output logic o_wr_done,
   output logic o_found,
   output logic [AW-1:0] o_index,
   output logic [ENTRIES/2-1:0] o_lines,
   output logic o_upper,
   output logic o_valid
);

   localparam int HALF = ENTRIES / 2;

   typedef struct packed {
      logic [ENTRIES-1:0][W-1:0] data;
      logic [ENTRIES-1:0][W-1:0] dc;
      logic [ENTRIES-1:0] used;
      logic [1:0] wcnt;
      logic whold;
      logic wr_done;
      logic [ENTRIES-1:0] hits;
      logic pend;
      logic found;
      logic [AW-1:0] index;
      logic [HALF-1:0] lines;
      logic upper;
      logic valid;
   } cam_t;

   cam_t s;
   cam_t next_s;

   function automatic logic entry_hit(input logic used, input logic [W-1:0] data,
                                      input logic [W-1:0] dc, input logic [W-1:0] key);
      return used && (((data ^ key) & ~dc) == '0);
   endfunction : entry_hit

   always_comb
   begin
      logic [1:0] last;
      logic [ENTRIES-1:0] hit;
      next_s = s;
      last = i_wr_care ? CAM_WR_DC_CYCLES - 2'h1 : CAM_WR_CYCLES - 2'h1;
      hit = '0;
      next_s.wr_done = 1'b0;
      next_s.valid = 1'b0;
      // RL16 multi-cycle write
      if (!i_wr)
      begin
         next_s.wcnt = 2'h0;
         next_s.whold = 1'b0;
      end
      else if (!s.whold)
      begin
         if (s.wcnt == last)
         begin
            next_s.data[i_wr_addr] = i_wr_data;
            // RL6 store don't-care marks
            next_s.dc[i_wr_addr] = i_wr_care ? i_wr_dc : '0;
            next_s.used[i_wr_addr] = 1'b1;
            next_s.wcnt = 2'h0;
            next_s.whold = 1'b1;
            next_s.wr_done = 1'b1;
         end
         else
         begin
            next_s.wcnt = s.wcnt + 2'h1;
         end
      end
      // RL17 parallel compare
      for (int i = 0; i < ENTRIES; i++)
      begin
         // RL7 masked bits ignored
         hit[i] = entry_hit(s.used[i], s.data[i], s.dc[i], i_key);
      end
      if (i_ce && i_search)
      begin
         next_s.hits = hit;
         next_s.found = |hit;
         next_s.index = '0;
         // RL13 binary index, lowest wins
         for (int i = ENTRIES - 1; i >= 0; i--)
         begin
            if (hit[i])
            begin
               next_s.index = AW'(i);
            end
         end
         // RL14 lower half first
         next_s.lines = hit[HALF-1:0];
         next_s.upper = 1'b0;
         next_s.pend = 1'b1;
         next_s.valid = 1'b1;
      end
      else if (i_ce && s.pend)
      begin
         // RL14 upper half second
         next_s.lines = s.hits[ENTRIES-1:HALF];
         next_s.upper = 1'b1;
         next_s.pend = 1'b0;
         next_s.valid = 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign o_wr_done = s.wr_done;
   // RL18 found flag
   assign o_found = s.found;
   assign o_index = s.index;
   assign o_lines = s.lines;
   assign o_upper = s.upper;
   assign o_valid = s.valid;

endmodule : cam_core

/* File: hdl/embedded_memory_block.sv */
// embedded memory block: ram, rom, fifo or cam storage plus macrocell registers
// assumes one system clock; port rates and block clocks arrive as enable pulses
//
// Overview of operation
// RL1: one of ram, rom, fifo, cam per instance
// RL2: writes registered; optional extra read output stage
// RL3: read and write together, separate port rates
// RL4: cam holds 32 words of 32 bits
// RL5: fabric merges several cams for larger sizes
// RL6: cam write carries per-bit don't-care marks
// RL7: don't-care bits never block a match
// RL8: macrocell register acts as D, T, JK, SR
// RL9: bypass sends combinational result to output; here i_mc_a reaches o_mc_out through the output register, one cycle later
// RL10: macrocell picks one of two block clocks
// RL11: each block clock gated by its enable
// RL12: mixed edges use both clock lines
// RL13: encoded output gives matching entry index
// RL14: unencoded output: 32 hits over two cycles
// RL15: writer avoids duplicates when using encoded output
// RL16: cam write lasts two or three cycles
// RL17: search compares all entries in parallel
// RL18: found flag separates miss from index zero
`timescale 1ns/1ps
module embedded_memory_block
   import emb_pkg::*;
#(
   parameter mode_t MODE = MODE_RAM,
   parameter bit OUT_REG = 1'b0,
   parameter int W = WORD_W,
   parameter int D = DEPTH,
   parameter int AW = ADDR_W,
   parameter int MC = N_MC,
   parameter logic [W-1:0] ROM_INIT = RST_WORD
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce_a,
   input wire logic i_ce_b,
   input wire logic i_wr_en,
   input wire logic [AW-1:0] i_wr_addr,
   input wire logic [W-1:0] i_wr_data,
   input wire logic i_rd_en,
   input wire logic [AW-1:0] i_rd_addr,
   output logic [W-1:0] o_rd_data,
   output logic o_rd_valid,
   output logic o_fifo_full,
   output logic o_fifo_empty,
   output logic [AW:0] o_fifo_count,
   input wire logic i_cam_care,
   input wire logic [W-1:0] i_cam_dc,
   input wire logic i_search,
   input wire logic [W-1:0] i_key,
   output logic o_cam_wr_done,
   output logic o_found,
   output logic [AW-1:0] o_index,
   output logic [D/2-1:0] o_lines,
   output logic o_upper,
   output logic o_match_valid,
   input wire logic [1:0] i_clk_ena,
   input wire logic i_dual_edge,
   input wire logic [MC-1:0][1:0] i_mc_kind,
   input wire logic [MC-1:0] i_mc_clk_sel,
   input wire logic [MC-1:0] i_mc_bypass,
   input wire logic [MC-1:0] i_mc_a,
   input wire logic [MC-1:0] i_mc_b,
   output logic [MC-1:0] o_mc_out
);

   // ==========================================================
   // state

   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
      logic rd_pend;
      logic rd_pend_q;
      logic [W-1:0] rd_q;
      logic full;
      logic empty;
      logic [MC-1:0] mc_q;
      logic [MC-1:0] mc_out;
   } blk_t;

   // fifo starts empty, everything else clear
   localparam blk_t RST_S = '{empty: 1'b1, default: '0};

   blk_t s;
   blk_t next_s;

   logic mem_we;
   logic [AW-1:0] mem_waddr;
   logic mem_re;
   logic [AW-1:0] mem_raddr;
   logic [W-1:0] mem_rdata;
   logic push;
   logic pop;
   logic [1:0] line_ena;
   logic [MC-1:0] mc_ena;
   logic [MC-1:0] mc_d;
   logic cam_wr;
   logic cam_search;

   // ==========================================================
   // macrocell register behaviour

   function automatic logic ff_next(input logic [1:0] kind, input logic q,
                                    input logic a, input logic b);
      logic r;
      r = q;
      unique case (ff_kind_t'(kind))
         FF_D: r = a;
         FF_T: r = q ^ a;
         FF_JK: r = (a & ~q) | (~b & q);
         FF_SR: r = a | (~b & q);
      endcase
      return r;
   endfunction : ff_next

   // ==========================================================
   // mode decode

   function automatic logic mode_is(input mode_t m);
      return MODE == m;
   endfunction : mode_is

   // ==========================================================
   // storage port steering

   // RL1 mode chosen per instance
   assign push = mode_is(MODE_FIFO) && i_ce_a && i_wr_en && !s.full;
   assign pop = mode_is(MODE_FIFO) && i_ce_b && i_rd_en && !s.empty;

   // cam requests exist only in cam mode
   assign cam_wr = mode_is(MODE_CAM) && i_wr_en;
   assign cam_search = mode_is(MODE_CAM) && i_search;

   always_comb
   begin
      mem_we = 1'b0;
      mem_waddr = i_wr_addr;
      mem_re = 1'b0;
      mem_raddr = i_rd_addr;
      unique case (MODE)
         MODE_RAM:
         begin
            // RL3 write and read ports independent
            mem_we = i_ce_a && i_wr_en;
            mem_re = i_ce_b && i_rd_en;
         end
         MODE_ROM:
         begin
            mem_re = i_ce_b && i_rd_en;
         end
         MODE_FIFO:
         begin
            mem_we = push;
            mem_waddr = s.wr_ptr;
            mem_re = pop;
            mem_raddr = s.rd_ptr;
         end
         MODE_CAM:
         begin
            mem_we = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // block clock lines

   // RL12 dual edge takes both lines
   assign line_ena[0] = i_clk_ena[0];
   assign line_ena[1] = i_dual_edge ? i_clk_ena[0] : i_clk_ena[1];

   generate
      for (genvar g = 0; g < MC; g++)
      begin : g_mc
         // RL10 one of two clocks
         // RL11 clock paired with enable
         assign mc_ena[g] = line_ena[i_mc_clk_sel[g]];
         // RL8 programmable register kind
         assign mc_d[g] = ff_next(i_mc_kind[g], s.mc_q[g], i_mc_a[g], i_mc_b[g]);
      end
   endgenerate

   // ==========================================================
   // next state

   always_comb
   begin
      next_s = s;
      // RL2 optional output stage
      next_s.rd_pend = mem_re;
      next_s.rd_pend_q = s.rd_pend;
      if (s.rd_pend)
      begin
         next_s.rd_q = mem_rdata;
      end
      if (push)
      begin
         next_s.wr_ptr = s.wr_ptr + AW'(1);
      end
      if (pop)
      begin
         next_s.rd_ptr = s.rd_ptr + AW'(1);
      end
      if (push && !pop)
      begin
         next_s.count = s.count + (AW + 1)'(1);
      end
      else if (pop && !push)
      begin
         next_s.count = s.count - (AW + 1)'(1);
      end
      next_s.full = (next_s.count == (AW + 1)'(D));
      next_s.empty = (next_s.count == RST_COUNT);
      for (int i = 0; i < MC; i++)
      begin
         if (mc_ena[i])
         begin
            next_s.mc_q[i] = mc_d[i];
         end
         // RL9 bypass: i_mc_a registered into mc_out in place of mc_q
         next_s.mc_out[i] = i_mc_bypass[i] ? i_mc_a[i] : next_s.mc_q[i];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         s <= RST_S;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ==========================================================
   // storage and cam

   // RL2 registered write port
   mem_store #(
      .W(W),
      .D(D),
      .AW(AW),
      .INIT((MODE == MODE_ROM) ? ROM_INIT : RST_WORD)
   ) u_store (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_we(mem_we),
      .i_waddr(mem_waddr),
      .i_wdata(i_wr_data),
      .i_re(mem_re),
      .i_raddr(mem_raddr),
      .o_rdata(mem_rdata)
   );

   // RL4 cam of 32 by 32
   cam_core #(
      .ENTRIES(D),
      .W(W),
      .AW(AW)
   ) u_cam (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce_b),
      .i_wr(cam_wr),
      .i_wr_care(i_cam_care),
      .i_wr_addr(i_wr_addr),
      .i_wr_data(i_wr_data),
      .i_wr_dc(i_cam_dc),
      .i_search(cam_search),
      .i_key(i_key),
      .o_wr_done(o_cam_wr_done),
      .o_found(o_found),
      .o_index(o_index),
      .o_lines(o_lines),
      .o_upper(o_upper),
      .o_valid(o_match_valid)
   );

   // ==========================================================
   // outputs

   // RL2 output stage fixed at build time
   generate
      if (OUT_REG)
      begin : g_out_reg
         assign o_rd_data = s.rd_q;
         assign o_rd_valid = s.rd_pend_q;
      end
      else
      begin : g_out_direct
         assign o_rd_data = mem_rdata;
         assign o_rd_valid = s.rd_pend;
      end
   endgenerate
   assign o_fifo_full = s.full;
   assign o_fifo_empty = s.empty;
   assign o_fifo_count = s.count;
   assign o_mc_out = s.mc_out;

endmodule : embedded_memory_block

/* File: sim/emb_asserts.sv */
// checker: cam write timing, search results, macrocell registers
// assumes a bind to embedded_memory_block in cam mode
`timescale 1ns/1ps
module emb_asserts
   import emb_pkg::*;
#(
   parameter int D = DEPTH,
   parameter int AW = ADDR_W,
   parameter int MC = N_MC
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_wr_en,
   input wire logic i_cam_care,
   input wire logic o_cam_wr_done,
   input wire logic i_ce_b,
   input wire logic i_search,
   input wire logic o_found,
   input wire logic [AW-1:0] o_index,
   input wire logic [D/2-1:0] o_lines,
   input wire logic o_upper,
   input wire logic o_match_valid,
   input wire logic [1:0] i_clk_ena,
   input wire logic i_dual_edge,
   input wire logic [MC-1:0][1:0] i_mc_kind,
   input wire logic [MC-1:0] i_mc_clk_sel,
   input wire logic [MC-1:0] i_mc_bypass,
   input wire logic [MC-1:0] i_mc_a,
   input wire logic [MC-1:0] o_mc_out
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ==========================================
   // cam write
   sequence s_wait2; !o_cam_wr_done [*2]; endsequence
   sequence s_wait3; !o_cam_wr_done [*3]; endsequence
   property p_wr2; $rose(i_wr_en) && !i_cam_care |-> s_wait2 ##1 o_cam_wr_done; endproperty
   property p_wr3; $rose(i_wr_en) && i_cam_care |-> s_wait3 ##1 o_cam_wr_done; endproperty
   property p_done; o_cam_wr_done |=> !o_cam_wr_done; endproperty
   a_wr2: assert property (p_wr2) else $error("plain write done late");
   a_wr3: assert property (p_wr3) else $error("masked write done late");
   a_done: assert property (p_done) else $error("done not a pulse");
   // ==========================================
   // search
   property p_srch; i_ce_b && i_search |=> o_match_valid && !o_upper; endproperty
   property p_enc;
      o_match_valid && !o_upper && (|o_lines) |-> o_found && !o_index[AW-1]
         && o_lines[o_index[3:0]] && ((o_lines & ((16'h1 << o_index[3:0]) - 16'h1)) == 16'h0);
   endproperty
   property p_miss; o_match_valid && !o_found |-> o_lines == '0; endproperty
   a_srch: assert property (p_srch) else $error("no low half");
   a_enc: assert property (p_enc) else $error("index off hit");
   a_miss: assert property (p_miss) else $error("hit without found");
   // ==========================================
   // macrocells
   property p_d;
      i_mc_kind[0] == 2'h0 && !i_mc_bypass[0] && !i_dual_edge && i_clk_ena[i_mc_clk_sel[0]]
         |=> o_mc_out[0] == $past(i_mc_a[0]);
   endproperty
   property p_byp; i_mc_bypass[2] |=> o_mc_out[2] == $past(i_mc_a[2]); endproperty
   property p_hold;
      i_clk_ena == 2'h0 && i_mc_bypass == '0 && $past(i_mc_bypass) == '0
         |=> $stable(o_mc_out);
   endproperty
   a_d: assert property (p_d) else $error("d register wrong");
   a_byp: assert property (p_byp) else $error("bypass wrong");
   a_hold: assert property (p_hold) else $error("moved without enable");
endmodule : emb_asserts

bind embedded_memory_block emb_asserts #(.D(D), .AW(AW), .MC(MC)) emb_asserts_i (
   .i_clk, .i_rst, .i_wr_en, .i_cam_care, .o_cam_wr_done, .i_ce_b, .i_search,
   .o_found, .o_index, .o_lines, .o_upper, .o_match_valid, .i_clk_ena, .i_dual_edge,
   .i_mc_kind, .i_mc_clk_sel, .i_mc_bypass, .i_mc_a, .o_mc_out);

/* File: sim/cam_writer.sv */
// partner: fabric-side cam writer
// assumes the block's clock and reset
`timescale 1ns/1ps
module cam_writer
   import emb_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_go,
   input wire logic i_care,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [WORD_W-1:0] i_data,
   input wire logic [WORD_W-1:0] i_dc,
   input wire logic i_done,
   output logic o_wr_en,
   output logic o_care,
   output logic [ADDR_W-1:0] o_addr,
   output logic [WORD_W-1:0] o_data,
   output logic [WORD_W-1:0] o_dc,
   output logic [1:0] o_lat
);
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_wr_en <= 1'b0;
         o_lat <= 2'h0;
         o_care <= 1'b0;
         o_addr <= '0;
         o_data <= '0;
         o_dc <= '0;
      end
      else if (o_wr_en && i_done)
      begin
         o_wr_en <= 1'b0;
         o_addr <= ~o_addr;
         o_data <= ~o_data;
         o_dc <= ~o_dc;
      end
      else if (o_wr_en)
         o_lat <= o_lat + 2'h1;
      else if (i_go)
      begin
         o_wr_en <= 1'b1;
         o_lat <= 2'h0;
         o_care <= i_care;
         o_addr <= i_addr;
         o_data <= i_data;
         o_dc <= i_dc;
      end
   end
endmodule : cam_writer

/* File: sim/tb.sv */
// testbench: cam writes and searches, macrocell registers
// assumes cam mode and the cam_writer partner
`timescale 1ns/1ps
module tb
   import emb_pkg::*;
;
   logic clk, rst = 1'b1, ce_b = 1'b0, search = 1'b0, dual = 1'b0, go = 1'b0, care = 1'b0;
   logic [1:0] ena = 2'h0;
   logic [3:0] byp = 4'h0, mc_a = 4'h0, mc_b = 4'h0, mc_out;
   logic [4:0] addr = 5'h00, w_addr, idx;
   // keys fit one block, no merging
   logic [31:0] key = 32'h0, data = 32'h0, dc = 32'h0, w_data, w_dc;
   logic wr_en, w_care, done, found, upper, mvalid;
   logic [1:0] lat;
   logic [15:0] lines;
   int fail_count = 0, num_checks = 0, cycles = 0;

   embedded_memory_block #(.MODE(MODE_CAM)) embedded_memory_block_i (
      .i_clk(clk), .i_rst(rst), .i_ce_a(1'b0), .i_ce_b(ce_b), .i_wr_en(wr_en),
      .i_wr_addr(w_addr), .i_wr_data(w_data), .i_rd_en(1'b0), .i_rd_addr(5'h00),
      .o_rd_data(), .o_rd_valid(), .o_fifo_full(), .o_fifo_empty(), .o_fifo_count(),
      .i_cam_care(w_care), .i_cam_dc(w_dc), .i_search(search), .i_key(key),
      .o_cam_wr_done(done), .o_found(found), .o_index(idx), .o_lines(lines),
      .o_upper(upper), .o_match_valid(mvalid), .i_clk_ena(ena), .i_dual_edge(dual),
      .i_mc_kind(8'hE4), .i_mc_clk_sel(4'h2), .i_mc_bypass(byp), .i_mc_a(mc_a),
      .i_mc_b(mc_b), .o_mc_out(mc_out));

   cam_writer cam_writer_i (
      .i_clk(clk), .i_rst(rst), .i_go(go), .i_care(care), .i_addr(addr), .i_data(data),
      .i_dc(dc), .i_done(done), .o_wr_en(wr_en), .o_care(w_care), .o_addr(w_addr),
      .o_data(w_data), .o_dc(w_dc), .o_lat(lat));

   // ==========================================
   // clock and watchdog
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         conclude();
      end
   end

   // ==========================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude;
      if (fail_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   task automatic cam_write(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m,
      input logic c);
      int n;
      @(posedge clk);
      go <= 1'b1;
      addr <= a;
      data <= d;
      dc <= m;
      care <= c;
      @(posedge clk);
      go <= 1'b0;
      #1;
      for (n = 0; n < 8 && wr_en !== 1'b0; n++)
         @(posedge clk) #1;
      chk(lat, c ? CAM_WR_DC_CYCLES : CAM_WR_CYCLES);
   endtask : cam_write

   task automatic find(input logic [31:0] k, input logic f, input logic [4:0] ix,
      input logic [15:0] lo, input logic [15:0] hi);
      @(posedge clk);
      search <= 1'b1;
      ce_b <= 1'b1;
      key <= k;
      @(posedge clk);
      search <= 1'b0;
      ce_b <= 1'b0;
      #1;
      chk({mvalid, upper, found}, {2'b10, f});
      if (f)
         chk(idx, ix);
      chk(lines, lo);
      @(posedge clk);
      ce_b <= 1'b1;
      @(posedge clk);
      ce_b <= 1'b0;
      #1;
      chk({mvalid, upper, lines}, {2'b11, hi});
   endtask : find

   task automatic mc_step(input logic [1:0] e, input logic [3:0] a, input logic [3:0] b,
      input logic [3:0] p, input logic du, input logic [3:0] exp);
      @(posedge clk);
      ena <= e;
      mc_a <= a;
      mc_b <= b;
      byp <= p;
      dual <= du;
      @(posedge clk);
      ena <= 2'h0;
      #1;
      chk(mc_out, exp);
   endtask : mc_step

   // ==========================================
   // main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      cam_write(5'h03, 32'hA5A50003, 32'h0, 1'b0);
      cam_write(5'h0C, 32'h12345600, 32'h000000FF, 1'b1);
      cam_write(5'h14, 32'hC0DE0020, 32'h0, 1'b0);
      find(32'hA5A50003, 1'b1, 5'h03, 16'h0008, 16'h0);
      find(32'h123456EE, 1'b1, 5'h0C, 16'h1000, 16'h0);
      find(32'h123457EE, 1'b0, 5'h00, 16'h0, 16'h0);
      find(32'hC0DE0020, 1'b1, 5'h14, 16'h0, 16'h0010);
      find(32'h0, 1'b0, 5'h00, 16'h0, 16'h0);
      mc_step(2'h1, 4'hF, 4'h0, 4'h0, 1'b0, 4'hD);
      mc_step(2'h2, 4'hF, 4'h0, 4'h0, 1'b0, 4'hF);
      mc_step(2'h1, 4'h0, 4'hF, 4'h4, 1'b0, 4'h2);
      mc_step(2'h2, 4'h4, 4'h0, 4'h4, 1'b0, 4'h6);
      mc_step(2'h0, 4'hF, 4'h0, 4'h0, 1'b0, 4'h2);
      mc_step(2'h1, 4'hF, 4'h0, 4'h0, 1'b1, 4'hD);
      conclude();
   end
endmodule : tb
